// ==== epv_pkg.sv ====
// package: constants, types and register map of the program/verify port
package epv_pkg;

  // clock and programming pulse timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PULSE_LOW_MIN_US = 90;
  localparam int PULSE_LOW_MAX_US = 110;
  localparam int PULSE_HIGH_MIN_US = 10;
  localparam int PULSE_LOW_MIN_CYC = (PULSE_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_LOW_MAX_CYC = (PULSE_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int PULSE_HIGH_MIN_CYC = (PULSE_HIGH_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [4:0] PULSES_PER_WRITE = 5'h19;

  // memory geometry and special addresses
  localparam int CODE_AW = 12;
  localparam int CODE_DEPTH = 4096;
  localparam int ENC_AW = 5;
  localparam int ENC_DEPTH = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ENC_LAST_ADDR = 16'h001F;
  localparam logic [CODE_AW-1:0] SIG_ADDR_MAKER = 12'h030;
  localparam logic [CODE_AW-1:0] SIG_ADDR_PART = 12'h031;

  // write queue
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_W = 5;

  // register map, byte addresses on the Avalon slave
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_COMMIT_EN_BIT = 0;
  localparam logic CTRL_COMMIT_EN_RESET = 1'b1;
  localparam int STAT_SEC1_BIT = 0;
  localparam int STAT_SEC2_BIT = 1;
  localparam int STAT_ENC_BIT = 2;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_PCNT_LSB = 4;
  localparam int STAT_LVL_LSB = 9;

  typedef enum {
    MODE_NONE,
    MODE_PROG_CODE,
    MODE_PROG_ENC,
    MODE_PROG_SEC1,
    MODE_PROG_SEC2,
    MODE_VERIFY,
    MODE_SIGNATURE
  } epv_mode_t;

  typedef enum logic [1:0] {
    WK_CODE,
    WK_ENC,
    WK_SEC1,
    WK_SEC2
  } epv_wkind_t;

  typedef enum {
    PG_IDLE,
    PG_TRAIN,
    PG_PUSH,
    PG_DONE
  } epv_pg_state_t;

  // control pins seen by the device; vpp_level is high while the pin sits at programming voltage
  typedef struct packed {
    logic rst;
    logic fetch_strobe_pin;
    logic write_pulse_pin;
    logic high_voltage_pin;
    logic vpp_level;
    logic cycle_enable_pin;
    logic mode_sel_pin_a;
    logic mode_sel_pin_b;
    logic mode_sel_pin_c;
  } epv_pins_t;

  typedef struct packed {
    epv_wkind_t kind;
    logic [15:0] addr;
    logic [7:0] data;
  } epv_wrec_t;

endpackage : epv_pkg

// ==== epv_port.sv ====
// program/verify port: write queue and top level with pulse train, memories and Avalon slave
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module epv_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = level != LVL_W'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      level <= LVL_W'(level + {{(LVL_W-1){1'b0}}, push} - {{(LVL_W-1){1'b0}}, pop});
    end
  end
endmodule : epv_fifo

module epv_port #(
  parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h3C   // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire epv_pkg::epv_pins_t pins,
  input wire logic [15:0] addr_pins,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  function automatic epv_pkg::epv_mode_t decode_mode(input epv_pkg::epv_pins_t p);
    logic prog_base;
    logic read_base;
    prog_base = p.rst && !p.fetch_strobe_pin && p.vpp_level && p.cycle_enable_pin;
    read_base = p.rst && !p.fetch_strobe_pin && p.write_pulse_pin && p.high_voltage_pin && !p.vpp_level
                && !p.cycle_enable_pin && !p.mode_sel_pin_a;
    decode_mode = epv_pkg::MODE_NONE;
    if (prog_base && !p.mode_sel_pin_a && p.mode_sel_pin_b && p.mode_sel_pin_c) begin
      decode_mode = epv_pkg::MODE_PROG_CODE;
    end else if (prog_base && !p.mode_sel_pin_a && p.mode_sel_pin_b && !p.mode_sel_pin_c) begin
      decode_mode = epv_pkg::MODE_PROG_ENC;
    end else if (prog_base && p.mode_sel_pin_a && p.mode_sel_pin_b && p.mode_sel_pin_c) begin
      decode_mode = epv_pkg::MODE_PROG_SEC1;
    end else if (prog_base && p.mode_sel_pin_a && !p.mode_sel_pin_b && !p.mode_sel_pin_c) begin
      decode_mode = epv_pkg::MODE_PROG_SEC2;
    end else if (read_base && p.mode_sel_pin_b && p.mode_sel_pin_c) begin
      decode_mode = epv_pkg::MODE_VERIFY;
    end else if (read_base && !p.mode_sel_pin_b && !p.mode_sel_pin_c) begin
      decode_mode = epv_pkg::MODE_SIGNATURE;
    end
  endfunction : decode_mode

  // storage: erased cells read as all ones
  logic [7:0] code_mem [epv_pkg::CODE_DEPTH];
  logic [7:0] enc_mem [epv_pkg::ENC_DEPTH];

  initial begin
    for (int i = 0; i < epv_pkg::CODE_DEPTH; i++) begin
      code_mem[i] = epv_pkg::ERASED_BYTE;
    end
    for (int i = 0; i < epv_pkg::ENC_DEPTH; i++) begin
      enc_mem[i] = epv_pkg::ERASED_BYTE;
    end
  end

  // mode decode
  epv_pkg::epv_mode_t mode;
  wire is_prog = mode == epv_pkg::MODE_PROG_CODE || mode == epv_pkg::MODE_PROG_ENC
                 || mode == epv_pkg::MODE_PROG_SEC1 || mode == epv_pkg::MODE_PROG_SEC2;
  epv_pkg::epv_wkind_t cur_kind;
  epv_pkg::epv_wrec_t cur_rec;

  assign mode = decode_mode(pins);
  assign cur_kind = mode == epv_pkg::MODE_PROG_ENC ? epv_pkg::WK_ENC :
                    mode == epv_pkg::MODE_PROG_SEC1 ? epv_pkg::WK_SEC1 :
                    mode == epv_pkg::MODE_PROG_SEC2 ? epv_pkg::WK_SEC2 : epv_pkg::WK_CODE;
  assign cur_rec = '{kind: cur_kind, addr: addr_pins, data: data_in};

  // pulse train measurement
  logic wp_q;
  logic [epv_pkg::CNT_W-1:0] low_cnt;
  logic [epv_pkg::CNT_W-1:0] high_cnt;
  logic [4:0] pulse_cnt;
  epv_pkg::epv_pg_state_t pg_state;
  epv_pkg::epv_wrec_t rec;
  logic fault;

  wire wp_fell = wp_q && !pins.write_pulse_pin;
  wire wp_rose = !wp_q && pins.write_pulse_pin;
  wire [epv_pkg::CNT_W-1:0] low_min = epv_pkg::CNT_W'(epv_pkg::PULSE_LOW_MIN_CYC);
  wire [epv_pkg::CNT_W-1:0] low_max = epv_pkg::CNT_W'(epv_pkg::PULSE_LOW_MAX_CYC);
  wire [epv_pkg::CNT_W-1:0] high_min = epv_pkg::CNT_W'(epv_pkg::PULSE_HIGH_MIN_CYC);
  wire pulse_ok = wp_rose && low_cnt >= low_min && low_cnt <= low_max;
  wire pulse_bad = wp_rose && !pulse_ok;
  wire gap_bad = wp_fell && pulse_cnt != 5'h00 && high_cnt < high_min;
  wire rec_changed = cur_rec != rec;
  wire in_train = pg_state == epv_pkg::PG_TRAIN;
  wire last_pulse = pulse_ok && pulse_cnt == 5'(epv_pkg::PULSES_PER_WRITE - 5'h01);
  wire [epv_pkg::CNT_W-1:0] next_low_cnt = pins.write_pulse_pin ? '0 :
                                          (&low_cnt ? low_cnt : epv_pkg::CNT_W'(low_cnt + 1'b1));
  wire [epv_pkg::CNT_W-1:0] next_high_cnt = !pins.write_pulse_pin ? '0 :
                                           (&high_cnt ? high_cnt : epv_pkg::CNT_W'(high_cnt + 1'b1));

  // write queue between the pulse train and the memory engine
  logic fifo_in_ready;
  logic fifo_out_valid;
  epv_pkg::epv_wrec_t fifo_out;
  logic [epv_pkg::FIFO_LVL_W-1:0] fifo_level;
  logic commit_en;
  wire fifo_pop = fifo_out_valid && commit_en;

  epv_fifo #(
    .WIDTH($bits(epv_pkg::epv_wrec_t)),
    .DEPTH(epv_pkg::FIFO_DEPTH),
    .LVL_W(epv_pkg::FIFO_LVL_W)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(pg_state == epv_pkg::PG_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(rec),
    .out_valid(fifo_out_valid),
    .out_ready(commit_en),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= 1'b1;
      low_cnt <= '0;
      high_cnt <= '0;
    end else begin
      wp_q <= pins.write_pulse_pin;
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_state <= epv_pkg::PG_IDLE;
      pulse_cnt <= '0;
      rec <= '0;
    end else begin
      case (pg_state)
        epv_pkg::PG_IDLE: begin
          if (is_prog) begin
            pg_state <= epv_pkg::PG_TRAIN;
            pulse_cnt <= '0;
            rec <= cur_rec;
          end
        end
        epv_pkg::PG_TRAIN: begin
          if (!is_prog) begin
            pg_state <= epv_pkg::PG_IDLE;
          end else if (rec_changed) begin
            pulse_cnt <= '0;
            rec <= cur_rec;
          end else if (last_pulse) begin
            pulse_cnt <= epv_pkg::PULSES_PER_WRITE;
            pg_state <= epv_pkg::PG_PUSH;
          end else if (pulse_ok) begin
            pulse_cnt <= 5'(pulse_cnt + 1'b1);
          end
        end
        epv_pkg::PG_PUSH: begin
          if (fifo_in_ready) begin
            pg_state <= epv_pkg::PG_DONE;
          end
        end
        epv_pkg::PG_DONE: begin
          if (!is_prog) begin
            pg_state <= epv_pkg::PG_IDLE;
          end else if (rec_changed) begin
            pg_state <= epv_pkg::PG_TRAIN;
            pulse_cnt <= '0;
            rec <= cur_rec;
          end
        end
        default: begin
          pg_state <= epv_pkg::PG_IDLE;
        end
      endcase
    end
  end

  // memory engine; security bits are sticky and block code and table writes
  logic sec1;
  logic sec2;
  logic enc_done;
  wire sec_any = sec1 || sec2;
  wire code_we = fifo_pop && fifo_out.kind == epv_pkg::WK_CODE && !sec_any;
  wire enc_we = fifo_pop && fifo_out.kind == epv_pkg::WK_ENC && !sec_any
                && fifo_out.addr <= epv_pkg::ENC_LAST_ADDR;

  always @(posedge clk) begin
    if (code_we) begin
      code_mem[fifo_out.addr[epv_pkg::CODE_AW-1:0]] <= fifo_out.data;
    end
    if (enc_we) begin
      enc_mem[fifo_out.addr[epv_pkg::ENC_AW-1:0]] <= fifo_out.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec1 <= 1'b0;
      sec2 <= 1'b0;
      enc_done <= 1'b0;
    end else begin
      sec1 <= sec1 || (fifo_pop && fifo_out.kind == epv_pkg::WK_SEC1);
      sec2 <= sec2 || (fifo_pop && fifo_out.kind == epv_pkg::WK_SEC2);
      enc_done <= enc_done || enc_we;
    end
  end

  // verify and signature read path
  wire [epv_pkg::CODE_AW-1:0] rd_addr = addr_pins[epv_pkg::CODE_AW-1:0];
  wire [7:0] raw_byte = code_mem[rd_addr];
  wire [7:0] key_byte = enc_mem[rd_addr[epv_pkg::ENC_AW-1:0]];
  wire [7:0] verify_byte = enc_done ? ~(raw_byte ^ key_byte) : raw_byte;
  wire [7:0] sig_byte = rd_addr == epv_pkg::SIG_ADDR_MAKER ? MAKER_ID :
                        rd_addr == epv_pkg::SIG_ADDR_PART ? PART_ID : epv_pkg::ERASED_BYTE;
  wire verify_on = mode == epv_pkg::MODE_VERIFY && !sec2;
  wire sig_on = mode == epv_pkg::MODE_SIGNATURE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      data_out <= sig_on ? sig_byte : (verify_on ? verify_byte : '0);
      data_oe <= verify_on || sig_on;
    end
  end

  // Avalon slave: one wait cycle, then the answer
  wire avs_req = avs_read || avs_write;
  wire avs_take = avs_req && !avs_waitrequest;
  wire sel_ctrl = avs_address == epv_pkg::REG_CTRL;
  wire sel_status = avs_address == epv_pkg::REG_STATUS;
  wire fault_clr = avs_take && avs_write && sel_status && avs_byteenable[0]
                   && avs_writedata[epv_pkg::STAT_FAULT_BIT];
  wire fault_set = is_prog && in_train && (pulse_bad || gap_bad);
  logic [31:0] status_word;
  logic [31:0] rd_word;

  always_comb begin
    status_word = '0;
    status_word[epv_pkg::STAT_SEC1_BIT] = sec1;
    status_word[epv_pkg::STAT_SEC2_BIT] = sec2;
    status_word[epv_pkg::STAT_ENC_BIT] = enc_done;
    status_word[epv_pkg::STAT_FAULT_BIT] = fault;
    status_word[epv_pkg::STAT_PCNT_LSB +: 5] = pulse_cnt;
    status_word[epv_pkg::STAT_LVL_LSB +: epv_pkg::FIFO_LVL_W] = fifo_level;
  end

  assign rd_word = sel_ctrl ? {31'h00000000, commit_en} : (sel_status ? status_word : 32'h00000000);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      commit_en <= epv_pkg::CTRL_COMMIT_EN_RESET;
      fault <= 1'b0;
    end else begin
      avs_waitrequest <= !(avs_req && avs_waitrequest);
      if (avs_req && avs_waitrequest) begin
        avs_readdata <= avs_read ? rd_word : 32'h00000000;
      end
      if (avs_take && avs_write && sel_ctrl && avs_byteenable[0]) begin
        commit_en <= avs_writedata[epv_pkg::CTRL_COMMIT_EN_BIT];
      end
      fault <= fault_set || (fault && !fault_clr);
    end
  end

endmodule : epv_port
`default_nettype wire

// ==== epv_port_assertions.sv ====
// checker: port-level properties of the program/verify port
`timescale 1ns/1ns
`default_nettype none
module epv_port_assertions #(
  parameter logic [7:0] MAKER_ID = 8'hA5,
  parameter logic [7:0] PART_ID = 8'h3C
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire epv_pkg::epv_pins_t pins,
  input wire logic [15:0] addr_pins,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  wire logic base_m = pins.rst && !pins.fetch_strobe_pin && pins.write_pulse_pin && pins.high_voltage_pin
    && !pins.vpp_level && !pins.cycle_enable_pin && !pins.mode_sel_pin_a;
  wire logic ver_m = base_m && pins.mode_sel_pin_b && pins.mode_sel_pin_c;
  wire logic sig_m = base_m && !pins.mode_sel_pin_b && !pins.mode_sel_pin_c;
  wire logic req = avs_read || avs_write;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_sig_at(logic [11:0] a);
    sig_m && addr_pins[11:0] == a;
  endsequence
  sequence s_unmapped_rd;
    avs_read && avs_waitrequest && avs_address != 4'h0 && avs_address != 4'h4;
  endsequence
  a_sig_maker_byte: assert property (s_sig_at(12'h030) |=> data_oe && data_out == MAKER_ID)
    else $error("maker byte wrong");
  a_sig_part_byte: assert property (s_sig_at(12'h031) |=> data_oe && data_out == PART_ID)
    else $error("part byte wrong");
  a_sig_other_erased: assert property (sig_m && addr_pins[11:1] != 11'h018 |=> data_out == 8'hFF)
    else $error("signature space not erased");
  a_port_drive_src: assert property (data_oe |-> $past(ver_m || sig_m))
    else $error("port driven outside verify");
  a_port_float_exit: assert property (!(ver_m || sig_m) |=> !data_oe)
    else $error("port not floated");
  a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_wait_idle_high: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  a_unmapped_zero: assert property (s_unmapped_rd |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : epv_port_assertions

bind epv_port epv_port_assertions #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) i_epv_port_assertions (
  .clk(clk), .rst_n(rst_n), .pins(pins), .addr_pins(addr_pins), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// ==== epv_prog_model.sv ====
// programmer model: drives mode pins, address, port 0 and pulse trains
`timescale 1ns/1ns
`default_nettype none
module epv_prog_model (
  input wire logic clk,
  output epv_pkg::epv_pins_t pins,
  output logic [15:0] addr_pins,
  output logic [7:0] p0_drv,
  output logic p0_oe
);
  localparam logic [8:0] IDLE = 9'h040;
  initial begin
    pins = epv_pkg::epv_pins_t'(IDLE);
    addr_pins = 16'h0000;
    p0_drv = 8'h00;
    p0_oe = 1'b0;
  end
  task automatic drive(input logic [8:0] p, input logic [15:0] a, input logic [7:0] d, input logic oe);
    @(posedge clk);
    pins <= epv_pkg::epv_pins_t'(p);
    addr_pins <= a;
    p0_drv <= d;
    p0_oe <= oe;
  endtask : drive
  task automatic burn(input logic [8:0] p, input logic [15:0] a, input logic [7:0] d, input int n, input int lo);
    drive(p, a, d, 1'b1);
    repeat (160) @(posedge clk);
    pins.vpp_level <= 1'b1;
    repeat (200) @(posedge clk);
    repeat (n) begin
      pins.write_pulse_pin <= 1'b0;
      repeat (lo) @(posedge clk);
      pins.write_pulse_pin <= 1'b1;
      repeat (200) @(posedge clk);
    end
    pins.vpp_level <= 1'b0;
    repeat (160) @(posedge clk);
    // released lines show the inverse of the last value, port 0 goes to the pull-up
    drive(IDLE, ~a, ~d, 1'b0);
  endtask : burn
endmodule : epv_prog_model
`default_nettype wire

// ==== tb_eprom_program_verify_port.sv ====
// testbench: register access, verify, signature and programming of the port
`timescale 1ns/1ns
`default_nettype none
module tb_eprom_program_verify_port;
  localparam logic [8:0] CODE = 9'h16B;
  localparam logic [8:0] SEC1 = 9'h16F;
  localparam logic [8:0] VER = 9'h163;
  localparam logic [8:0] SIG = 9'h160;
  localparam logic [8:0] IDLE = 9'h040;
  localparam logic [7:0] MK = 8'h6E; // arbitrary value
  localparam logic [7:0] PT = 8'h91; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  epv_pkg::epv_pins_t pins;
  logic [15:0] addr_pins;
  logic [7:0] p0_drv, data_out;
  logic p0_oe, data_oe, avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  int num_errors = 0;
  int n_compared = 0;
  wire logic [7:0] data_in = data_oe ? data_out : (p0_oe ? p0_drv : 8'hFF);
  always #25 clk = ~clk;
  epv_prog_model i_epv_prog_model (.clk(clk), .pins(pins), .addr_pins(addr_pins), .p0_drv(p0_drv), .p0_oe(p0_oe));
  epv_port #(.MAKER_ID(MK), .PART_ID(PT)) i_epv_port (
    .clk(clk), .rst_n(rst_n), .pins(pins), .addr_pins(addr_pins), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    rd = avs_readdata;
    if (i >= 20) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, avs_waitrequest, 1'b0);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic look(input logic [8:0] p, input logic [15:0] a, input logic oe, input logic [7:0] exp);
    i_epv_prog_model.drive(p, a, 8'h00, 1'b0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({31'h0, data_oe}, {31'h0, oe});
    check({24'h0, data_in}, {24'h0, exp});
  endtask : look
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, epv_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, epv_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    avs_byteenable <= 4'hE;
    bus(1'b1, epv_pkg::REG_CTRL, 32'h0);
    avs_byteenable <= 4'hF;
    bus(1'b0, epv_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h1);
    $display("test registers done");
    look(SIG, 16'h0030, 1'b1, MK);
    look(SIG, 16'h0031, 1'b1, PT);
    look(SIG, 16'h0032, 1'b1, 8'hFF);
    look(VER, 16'h0123, 1'b1, 8'hFF);
    look(IDLE, 16'h0000, 1'b0, 8'hFF);
    $display("test read modes done");
    i_epv_prog_model.burn(CODE, 16'h0123, 8'h5C, 1, 100);
    bus(1'b0, epv_pkg::REG_STATUS, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    bus(1'b1, epv_pkg::REG_STATUS, 32'h8);
    bus(1'b0, epv_pkg::REG_STATUS, 32'h0);
    check({31'h0, rd[3]}, 32'h0);
    look(VER, 16'h0123, 1'b1, 8'hFF);
    $display("test short pulse done");
    bus(1'b1, epv_pkg::REG_CTRL, 32'h0);
    i_epv_prog_model.burn(CODE, 16'h0123, 8'h5C, 25, 1800);
    bus(1'b0, epv_pkg::REG_STATUS, 32'h0);
    check({27'h0, rd[13:9]}, 32'h1);
    check({28'h0, rd[3:0]}, 32'h0);
    check({27'h0, rd[8:4]}, {27'h0, epv_pkg::PULSES_PER_WRITE});
    look(VER, 16'h0123, 1'b1, 8'hFF);
    bus(1'b1, epv_pkg::REG_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    bus(1'b0, epv_pkg::REG_STATUS, 32'h0);
    check({27'h0, rd[13:9]}, 32'h0);
    look(VER, 16'h0123, 1'b1, 8'h5C);
    look(VER, 16'h0124, 1'b1, 8'hFF);
    $display("test code write done");
    i_epv_prog_model.burn(SEC1, 16'h0000, 8'h00, 25, 1800);
    bus(1'b0, epv_pkg::REG_STATUS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h1);
    look(VER, 16'h0123, 1'b1, 8'h5C);
    look(IDLE, 16'h0000, 1'b0, 8'hFF);
    $display("test security bit done");
    print_verdict();
  end
endmodule : tb_eprom_program_verify_port
`default_nettype wire
